// File: hw/rxd_pkg.sv
// Shared constants and state types for the receive DMA mode control.
package rxd_pkg;
  // Register offsets on the register port.
  localparam logic [15:0] OFS_SOF    = 16'h0026;
  localparam logic [15:0] OFS_FCOUNT = 16'h0028;
  localparam logic [15:0] OFS_BCOUNT = 16'h002A;
  localparam logic [15:0] OFS_RECEIVE_CONFIG_REGISTER  = 16'h0006;
  localparam logic [15:0] OFS_RXEVT  = 16'h0008;
  localparam logic [15:0] OFS_RECEIVE_CONTROL  = 16'h000A;
  localparam logic [15:0] OFS_BUFFER_CONFIG_REGISTER = 16'h0016;
  localparam logic [15:0] OFS_BUFEVT = 16'h0018;
  localparam logic [15:0] OFS_MISS   = 16'h0020;
  localparam logic [15:0] REG_RESET  = 16'h0000;
  // Field positions.
  localparam int CFG_BATCH  = 7;
  localparam int CFG_GOODIE = 8;
  localparam int CFG_EXCL   = 9;
  localparam int CFG_AUTO   = 10;
  localparam int CTL_ACCEPT = 8;
  localparam int BCF_DMAIE  = 7;
  localparam int BCF_E128IE = 11;
  localparam int BCF_RING   = 13;
  localparam int BCF_DESTIE = 15;
  localparam int EVT_GOOD   = 8;
  localparam int BEV_DMAFRM = 7;
  // Sizes.
  localparam int          FCOUNT_W        = 12;
  localparam int          MAX_FRAME_WORDS = 759;
  localparam logic [3:0]  BATCH_MAX       = 4'h8;
  localparam logic [16:0] RING_SMALL      = 17'h0_4000;
  localparam logic [16:0] RING_LARGE      = 17'h1_0000;
  // Timing at a 40 ns clock.
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          GAP_MIN_NS    = 9600;
  localparam int          GAP_MAX_NS    = 52000;
  localparam logic [10:0] GAP_MIN_CYC   = 11'((GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] GAP_MAX_CYC   = 11'(GAP_MAX_NS / CLK_PERIOD_NS);
  // State types.
  typedef enum logic {XF_IDLE, XF_RUN} rxd_xfer_t;
  typedef enum logic [2:0] {DR_IDLE, DR_RD, DR_WAIT, DR_PROC, DR_EVT, DR_EVW} rxd_drv_t;
endpackage : rxd_pkg

// File: hw/rxd_if.sv
// Interface joining the device end and the host end.
`timescale 1ns/100ps
interface rxd_if (
  input wire logic MCLK,
  input wire logic RST_N
);
  logic        reg_rd;
  logic        reg_wr;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        dma_req;
  logic        dma_ack_n;
  logic [15:0] dma_data;
  logic        irq;
  modport dev (input MCLK, RST_N, reg_rd, reg_wr, reg_addr, reg_wdata, dma_ack_n,
               output reg_rdata, dma_req, dma_data, irq);
  modport host (input MCLK, RST_N, reg_rdata, dma_req, dma_data, irq,
                output reg_rd, reg_wr, reg_addr, reg_wdata, dma_ack_n);
endinterface : rxd_if

// File: hw/rxd_dev.sv
// Device end: on-chip frame store, receive mode control and slave DMA engine.
`timescale 1ns/100ps
module rxd_dev
  import rxd_pkg::*;
#(
  parameter int RAM_AW  = 11,
  parameter int DESC_AW = 3
) (
  rxd_if.dev               BUS,
  input  wire logic        RX_SOF,
  input  wire logic        RX_DA_PASS,
  input  wire logic        RX_VALID,
  input  wire logic [15:0] RX_DATA,
  input  wire logic        RX_LAST,
  input  wire logic        RX_GOOD,
  input  wire logic [15:0] RX_STAT,
  input  wire logic        PIO_COMMIT,
  input  wire logic        PIO_SKIP,
  output logic             DMA_ACTIVE,
  output logic             BATCH_ACTIVE
);
  localparam int PW     = RAM_AW + 1;
  localparam int DESC_N = 1 << DESC_AW;

  logic [15:0]         cfg_r, ctl_r, bcf_r, sof_r, bcnt_r, miss_r, rdata_r, ring_wr_r;
  logic [FCOUNT_W-1:0] fcnt_r;
  logic                flag_r, evt_r, dma_r, batch_r, swp_r, zread_r;
  logic                seen_r, prevg_r, b2b_r, rx_on_r, ovf_r;
  logic [10:0]         gap_r;
  logic [3:0]          bn_r;
  logic [16:0]         cmt_r, pnd_r;
  logic [15:0]         ram [1 << RAM_AW];
  logic [PW-1:0]       wp_r, fs_r, rp_r, fc_r, left_r;
  logic [PW-1:0]       d_st [DESC_N];
  logic [PW-1:0]       d_len [DESC_N];
  logic [15:0]         d_stat [DESC_N];
  logic [DESC_AW:0]    dw_r, dr_r;
  logic [15:0]         q0_r, q1_r;
  logic [1:0]          qn_r;
  rxd_xfer_t           xs_r;

  // Register port decode; every read answers one cycle later from rdata_r.
  wire rd_fcnt  = BUS.reg_rd & (BUS.reg_addr == OFS_FCOUNT);
  wire rd_bcnt  = BUS.reg_rd & (BUS.reg_addr == OFS_BCOUNT);
  wire rd_miss  = BUS.reg_rd & (BUS.reg_addr == OFS_MISS);
  wire rd_rxevt = BUS.reg_rd & (BUS.reg_addr == OFS_RXEVT);
  wire [15:0] evt_word = dma_r ? 16'h0000 : (16'(evt_r) << EVT_GOOD);
  wire [15:0] bev_word = 16'(flag_r) << BEV_DMAFRM;
  wire [15:0] rd_mux =
    (BUS.reg_addr == OFS_SOF)    ? sof_r :
    (BUS.reg_addr == OFS_FCOUNT) ? {4'h0, fcnt_r} :
    (BUS.reg_addr == OFS_BCOUNT) ? bcnt_r :
    (BUS.reg_addr == OFS_RECEIVE_CONFIG_REGISTER)  ? cfg_r :
    (BUS.reg_addr == OFS_RXEVT)  ? evt_word :
    (BUS.reg_addr == OFS_RECEIVE_CONTROL)  ? ctl_r :
    (BUS.reg_addr == OFS_BUFFER_CONFIG_REGISTER) ? bcf_r :
    (BUS.reg_addr == OFS_BUFEVT) ? bev_word :
    (BUS.reg_addr == OFS_MISS)   ? miss_r : 16'h0000;

  // Mode selection from the configuration bits.
  wire excl    = cfg_r[CFG_EXCL];
  wire auto_sw = cfg_r[CFG_AUTO] & ~excl;
  wire bat_ok  = cfg_r[CFG_BATCH] & (excl | cfg_r[CFG_AUTO]);

  // Frame store.  A frame is kept only when it passes the filter and ends good.
  wire [PW-1:0] used     = wp_r - rp_r;
  wire          space_ok = (PW'(1 << RAM_AW) - used) >= PW'(MAX_FRAME_WORDS);
  wire          full     = used == PW'(1 << RAM_AW);
  wire          d_empty  = dw_r == dr_r;
  wire          d_full   = (dw_r - dr_r) == (DESC_AW + 1)'(DESC_N);
  wire          take     = RX_SOF & RX_DA_PASS & ~rx_on_r;
  wire          bfail    = RX_SOF & ~RX_DA_PASS;
  wire          wr_ok    = rx_on_r & RX_VALID & ~full & ~ovf_r;
  wire          eof      = rx_on_r & RX_VALID & RX_LAST;
  wire          lost     = eof & (~wr_ok | d_full);
  wire          acc      = eof & ~lost & RX_GOOD & ctl_r[CTL_ACCEPT];
  wire [PW-1:0] fwords   = wp_r - fs_r + PW'(wr_ok);
  wire          sw_req   = RX_SOF & RX_DA_PASS & auto_sw & ~dma_r & ~space_ok;

  // Head frame of the queue, the oldest one not yet moved.
  wire [DESC_AW-1:0] hd    = dr_r[DESC_AW-1:0];
  wire [PW-1:0]      hlen  = d_len[hd];
  wire [15:0]        bytes = 16'({hlen, 1'b0});
  wire [16:0]        rnd   = (17'(bytes) + 17'd7) & ~17'd3;
  wire [16:0]        ring  = bcf_r[BCF_RING] ? RING_LARGE : RING_SMALL;
  wire               room  = (ring - cmt_r - pnd_r) >= rnd;
  wire [15:0]        ring_nx = 16'((17'(ring_wr_r) + rnd) & (ring - 17'd1));

  // Transfer engine and its two-entry buffer toward the pins.
  wire          ack   = ~BUS.dma_ack_n;
  wire          start = (xs_r == XF_IDLE) & dma_r & ~d_empty & ~PIO_COMMIT & room;
  wire          done  = (xs_r == XF_RUN) & ack & (left_r == PW'(1));
  wire          pop   = ack & (qn_r != 2'd0);
  wire          push  = (xs_r == XF_RUN) & (fc_r < hlen + PW'(2)) & (qn_r != 2'd2);
  wire [PW-1:0] raddr = d_st[hd] + fc_r - PW'(2);
  wire [15:0]   din   = (fc_r == '0) ? d_stat[hd] : (fc_r == PW'(1)) ? bytes : ram[raddr[RAM_AW-1:0]];
  wire          skip  = PIO_SKIP & ~dma_r & (xs_r == XF_IDLE) & ~d_empty;

  // Batch, flag and mode transitions.
  wire          g_late    = ~rx_on_r & (gap_r > GAP_MAX_CYC);
  wire          bat_start = ~batch_r & bat_ok & acc & prevg_r & b2b_r;
  wire          bat_break = batch_r & ((eof & ~acc) | bfail | g_late);
  wire          bat_end   = batch_r & done & (bn_r == BATCH_MAX - 4'd1);
  wire          enter     = ~dma_r & (excl | (swp_r & ~PIO_COMMIT) | bat_start);
  wire          leave     = dma_r & ~excl & ~batch_r & ~swp_r & ~evt_r & zread_r & (xs_r == XF_IDLE);
  wire [FCOUNT_W-1:0] fcnt_nx = (rd_fcnt ? '0 : fcnt_r) + FCOUNT_W'(done);
  wire          set_flag  = (done & ~batch_r) | bat_end | bat_break;

  // Software registers and the read answer.
  always_ff @(posedge BUS.MCLK or negedge BUS.RST_N) begin
    if (!BUS.RST_N) begin
      cfg_r   <= REG_RESET;
      ctl_r   <= REG_RESET;
      bcf_r   <= REG_RESET;
      rdata_r <= REG_RESET;
    end else begin
      if (BUS.reg_wr && BUS.reg_addr == OFS_RECEIVE_CONFIG_REGISTER) cfg_r <= BUS.reg_wdata;
      if (BUS.reg_wr && BUS.reg_addr == OFS_RECEIVE_CONTROL) ctl_r <= BUS.reg_wdata;
      if (BUS.reg_wr && BUS.reg_addr == OFS_BUFFER_CONFIG_REGISTER) bcf_r <= BUS.reg_wdata;
      if (BUS.reg_rd) rdata_r <= rd_mux;
    end
  end

  // Frame store pointers; a dropped or lost frame rolls the write pointer back.
  always_ff @(posedge BUS.MCLK or negedge BUS.RST_N) begin
    if (!BUS.RST_N) begin
      wp_r    <= '0;
      fs_r    <= '0;
      rp_r    <= '0;
      dw_r    <= '0;
      dr_r    <= '0;
      rx_on_r <= 1'b0;
      ovf_r   <= 1'b0;
    end else begin
      if (take) begin
        rx_on_r <= 1'b1;
        ovf_r   <= 1'b0;
        fs_r    <= wp_r;
      end else if (eof) begin
        rx_on_r <= 1'b0;
      end else if (rx_on_r && RX_VALID && full) begin
        ovf_r <= 1'b1;
      end
      if (eof && !acc) wp_r <= fs_r;
      else if (wr_ok) wp_r <= wp_r + PW'(1);
      if (acc) dw_r <= dw_r + (DESC_AW + 1)'(1);
      if (done || skip) begin
        dr_r <= dr_r + (DESC_AW + 1)'(1);
        rp_r <= d_st[hd] + hlen;
      end
    end
  end

  // Storage arrays carry no reset; the pointers guard every read.
  always_ff @(posedge BUS.MCLK) begin
    if (wr_ok) ram[wp_r[RAM_AW-1:0]] <= RX_DATA;
    if (acc) begin
      d_st[dw_r[DESC_AW-1:0]]   <= fs_r;
      d_len[dw_r[DESC_AW-1:0]]  <= fwords;
      d_stat[dw_r[DESC_AW-1:0]] <= RX_STAT;
    end
  end

  // Transfer sequencer: status word, length word, then data.
  always_ff @(posedge BUS.MCLK or negedge BUS.RST_N) begin
    if (!BUS.RST_N) begin
      xs_r   <= XF_IDLE;
      fc_r   <= '0;
      left_r <= '0;
    end else begin
      case (xs_r)
        XF_IDLE: begin
          if (start) begin
            xs_r   <= XF_RUN;
            fc_r   <= '0;
            left_r <= hlen + PW'(2);
          end
        end
        XF_RUN: begin
          if (push) fc_r <= fc_r + PW'(1);
          if (ack) left_r <= left_r - PW'(1);
          if (done) xs_r <= XF_IDLE;
        end
        default: xs_r <= XF_IDLE;
      endcase
    end
  end

  // Two-entry buffer; a stalled acknowledge holds the sequencer through push.
  always_ff @(posedge BUS.MCLK or negedge BUS.RST_N) begin
    if (!BUS.RST_N) begin
      q0_r <= 16'h0000;
      q1_r <= 16'h0000;
      qn_r <= 2'd0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (qn_r == 2'd0) q0_r <= din;
          else q1_r <= din;
          qn_r <= qn_r + 2'd1;
        end
        2'b01: begin
          q0_r <= q1_r;
          qn_r <= qn_r - 2'd1;
        end
        2'b11: begin
          q0_r <= (qn_r == 2'd1) ? din : q1_r;
          q1_r <= din;
        end
        default: qn_r <= qn_r;
      endcase
    end
  end

  // Count, byte, offset and host-ring bookkeeping; a completion beats a read clear.
  always_ff @(posedge BUS.MCLK or negedge BUS.RST_N) begin
    if (!BUS.RST_N) begin
      fcnt_r    <= '0;
      bcnt_r    <= 16'h0000;
      sof_r     <= 16'h0000;
      ring_wr_r <= 16'h0000;
      cmt_r     <= 17'h0_0000;
      pnd_r     <= 17'h0_0000;
      zread_r   <= 1'b0;
      flag_r    <= 1'b0;
      miss_r    <= 16'h0000;
    end else begin
      fcnt_r <= fcnt_nx;
      bcnt_r <= (rd_bcnt ? 16'h0000 : bcnt_r) + (done ? bytes + 16'h0004 : 16'h0000);
      if (done) begin
        sof_r     <= ring_wr_r;
        ring_wr_r <= ring_nx;
      end
      if (rd_fcnt) begin
        cmt_r <= pnd_r;
        pnd_r <= done ? rnd : 17'h0_0000;
      end else if (done) begin
        pnd_r <= pnd_r + rnd;
      end
      // A zero read from before this DMA period began must not end it at once.
      if (done || enter) zread_r <= 1'b0;
      else if (rd_fcnt && fcnt_r == '0) zread_r <= 1'b1;
      flag_r <= set_flag | (flag_r & (fcnt_nx != '0));
      miss_r <= (rd_miss ? 16'h0000 : miss_r) + 16'(lost);
    end
  end

  // Mode, batch and good-frame event control.
  always_ff @(posedge BUS.MCLK or negedge BUS.RST_N) begin
    if (!BUS.RST_N) begin
      dma_r   <= 1'b0;
      swp_r   <= 1'b0;
      batch_r <= 1'b0;
      bn_r    <= 4'h0;
      evt_r   <= 1'b0;
      gap_r   <= 11'h000;
      seen_r  <= 1'b0;
      prevg_r <= 1'b0;
      b2b_r   <= 1'b0;
    end else begin
      if (enter) dma_r <= 1'b1;
      else if (leave) dma_r <= 1'b0;
      if (sw_req) swp_r <= 1'b1;
      else if (enter) swp_r <= 1'b0;
      // Outside a batch the event of a lost frame is never raised, so nothing is left to clear.
      evt_r <= (acc & ~dma_r & ~bat_start) | bat_break | (evt_r & ~enter & ~rd_rxevt);
      if (bat_start) batch_r <= 1'b1;
      else if (bat_break) batch_r <= 1'b0;
      if (bat_break || bat_end) bn_r <= 4'h0;
      else if (batch_r && done) bn_r <= bn_r + 4'h1;
      // The gap counter runs only between frames and saturates past the limit.
      if (eof) gap_r <= 11'h000;
      else if (!rx_on_r && gap_r <= GAP_MAX_CYC) gap_r <= gap_r + 11'h001;
      if (take) b2b_r <= seen_r & (gap_r >= GAP_MIN_CYC) & (gap_r <= GAP_MAX_CYC);
      if (eof) begin
        seen_r  <= 1'b1;
        prevg_r <= acc;
      end
    end
  end

  // Pins toward the DMA controller; the request falls with one word left.
  assign BUS.dma_req   = (xs_r == XF_RUN) & (qn_r != 2'd0) & (left_r > PW'(1));
  assign BUS.dma_data  = q0_r;
  assign BUS.reg_rdata = rdata_r;
  assign BUS.irq       = (flag_r & bcf_r[BCF_DMAIE]) | (evt_r & cfg_r[CFG_GOODIE]);
  assign DMA_ACTIVE    = dma_r;
  assign BATCH_ACTIVE  = batch_r;
endmodule : rxd_dev

// File: hw/rxd_host.sv
// Host end: system DMA controller and receive driver service loop.
`timescale 1ns/100ps
module rxd_host
  import rxd_pkg::*;
#(
  parameter logic [16:0] RING_BYTES = RING_SMALL,
  parameter int          LQ_AW      = 4
) (
  rxd_if.host              BUS,
  input  wire logic        DRV_EN,
  input  wire logic        CFG_WR,
  input  wire logic [15:0] CFG_ADDR,
  input  wire logic [15:0] CFG_DATA,
  input  wire logic        DMA_STALL,
  output logic             CFG_BUSY,
  output logic             WORD_VALID,
  output logic [15:0]      WORD_DATA,
  output logic [15:0]      FRAME_PTR
);
  logic              ack_r, req_d_r, owe_r, wv_r;
  logic [1:0]        idx_r;
  logic [15:0]       wd_r, ptr_r;
  logic [15:0]       lq [1 << LQ_AW];
  logic [LQ_AW:0]    lw_r, lr_r;
  logic [FCOUNT_W-1:0] n_r;
  rxd_drv_t          st_r;

  // A latched request earns one more acknowledge after it falls.
  wire ack_nxt = ~ack_r & ~DMA_STALL & (BUS.dma_req | owe_r);
  wire last    = ack_r & ~BUS.dma_req;
  wire lq_emp  = lw_r == lr_r;
  wire [15:0] lhead = lq[lr_r[LQ_AW-1:0]];
  wire [15:0] ptr_nx = 16'((17'(ptr_r) + 17'(lhead) + 17'd7) & ~17'd3 & (RING_BYTES - 17'd1));

  // DMA controller side: acknowledge pacing and word capture.
  always_ff @(posedge BUS.MCLK or negedge BUS.RST_N) begin
    if (!BUS.RST_N) begin
      ack_r   <= 1'b0;
      req_d_r <= 1'b0;
      owe_r   <= 1'b0;
      idx_r   <= 2'd0;
      wv_r    <= 1'b0;
      wd_r    <= 16'h0000;
      lw_r    <= '0;
    end else begin
      ack_r   <= ack_nxt;
      req_d_r <= BUS.dma_req;
      if (req_d_r && !BUS.dma_req) owe_r <= 1'b1;
      else if (ack_nxt && !BUS.dma_req) owe_r <= 1'b0;
      wv_r <= ack_r;
      if (ack_r) wd_r <= BUS.dma_data;
      if (last) idx_r <= 2'd0;
      else if (ack_r && idx_r != 2'd2) idx_r <= idx_r + 2'd1;
      if (ack_r && idx_r == 2'd1) lw_r <= lw_r + (LQ_AW + 1)'(1);
    end
  end

  // Length words queue up for the driver loop.
  always_ff @(posedge BUS.MCLK) begin
    if (ack_r && idx_r == 2'd1) lq[lw_r[LQ_AW-1:0]] <= BUS.dma_data;
  end

  // Driver loop: read the count, walk the frames, repeat until zero.
  always_ff @(posedge BUS.MCLK or negedge BUS.RST_N) begin
    if (!BUS.RST_N) begin
      st_r  <= DR_IDLE;
      n_r   <= '0;
      ptr_r <= 16'h0000;
      lr_r  <= '0;
    end else begin
      case (st_r)
        DR_IDLE: if (DRV_EN && BUS.irq && !CFG_WR) st_r <= DR_RD;
        DR_RD: st_r <= DR_WAIT;
        DR_WAIT: begin
          n_r  <= BUS.reg_rdata[FCOUNT_W-1:0];
          st_r <= (BUS.reg_rdata[FCOUNT_W-1:0] == '0) ? DR_EVT : DR_PROC;
        end
        DR_PROC: begin
          if (n_r == '0) begin
            st_r <= DR_RD;
          end else if (!lq_emp) begin
            ptr_r <= ptr_nx;
            lr_r  <= lr_r + (LQ_AW + 1)'(1);
            n_r   <= n_r - FCOUNT_W'(1);
          end
        end
        DR_EVT: st_r <= DR_EVW;
        DR_EVW: st_r <= DR_IDLE;
        default: st_r <= DR_IDLE;
      endcase
    end
  end

  // Register port strobes; user writes pass only while the loop is idle.
  assign BUS.reg_rd    = (st_r == DR_RD) | (st_r == DR_EVT);
  assign BUS.reg_wr    = (st_r == DR_IDLE) & CFG_WR;
  assign BUS.reg_addr  = (st_r == DR_EVT) ? OFS_RXEVT : (st_r == DR_IDLE) ? CFG_ADDR : OFS_FCOUNT;
  assign BUS.reg_wdata = CFG_DATA;
  assign BUS.dma_ack_n = ~ack_r;
  assign CFG_BUSY      = st_r != DR_IDLE;
  assign WORD_VALID    = wv_r;
  assign WORD_DATA     = wd_r;
  assign FRAME_PTR     = ptr_r;
endmodule : rxd_host

// File: verif/rxd_props.sv
// Concurrent checks on the link between the device end and the host end.
`timescale 1ns/100ps
module rxd_props
  import rxd_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        dma_req,
  input wire logic        dma_ack_n,
  input wire logic [15:0] dma_data,
  input wire logic        irq
);
  logic [15:0] receive_config_register_r;
  logic [15:0] buffer_config_register_r;

  // Shadow the mode bits from the write strobes, since the host never reads them back.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      receive_config_register_r  <= 16'h0000;
      buffer_config_register_r <= 16'h0000;
    end else if (reg_wr) begin
      if (reg_addr == OFS_RECEIVE_CONFIG_REGISTER) receive_config_register_r <= reg_wdata;
      if (reg_addr == OFS_BUFFER_CONFIG_REGISTER) buffer_config_register_r <= reg_wdata;
    end
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  // The upper nibble of the count carries no frames and must read as zero.
  a_count_upper_zero: assert property (reg_rd && reg_addr == OFS_FCOUNT |=> reg_rdata[15:12] == 4'h0)
    else $error("frame count upper bits not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_event_reads_zero: assert property (reg_rd && reg_addr == OFS_RXEVT && receive_config_register_r[CFG_EXCL] |=> reg_rdata == 16'h0000)
    else $error("receive event not zero in exclusive DMA");
  a_ack_one_cycle: assert property (!dma_ack_n |=> dma_ack_n)
    else $error("acknowledge longer than one cycle");
  // The last word is acknowledged with the request already low, and nothing may follow it at once.
  a_last_ack_alone: assert property (!dma_ack_n && !dma_req |=> dma_ack_n [*2])
    else $error("extra acknowledge after the last word");
  a_irq_masked: assert property (!buffer_config_register_r[BCF_DMAIE] && !receive_config_register_r[CFG_GOODIE] |-> !irq)
    else $error("interrupt with both enables clear");
  a_memory_mode_quiet: assert property (!receive_config_register_r[CFG_EXCL] && !receive_config_register_r[CFG_AUTO] |-> !dma_req)
    else $error("DMA request in memory mode");
  a_frame_flag_irq: assert property (!dma_ack_n && !dma_req && buffer_config_register_r[BCF_DMAIE] && !receive_config_register_r[CFG_BATCH] |=> irq)
    else $error("no interrupt after a frame completed");
endmodule : rxd_props

// File: verif/test_rx_dma_mode_control.sv
// Self-checking bench joining the device end and the host end of the receive DMA mode control.
`timescale 1ns/100ps
module test_rx_dma_mode_control import rxd_pkg::*;;
  logic        mclk       = 1'b0;
  logic        rst_n      = 1'b0;
  logic        rx_sof     = 1'b0;
  logic        rx_da_pass = 1'b0;
  logic        rx_valid   = 1'b0;
  logic [15:0] rx_data    = 16'h0000;
  logic        rx_last    = 1'b0;
  logic        rx_good    = 1'b0;
  logic [15:0] rx_stat    = 16'h0000;
  logic        pio_commit = 1'b0;
  logic        pio_skip   = 1'b0;
  logic        drv_en     = 1'b0;
  logic        cfg_wr     = 1'b0;
  logic [15:0] cfg_addr   = 16'h0000;
  logic [15:0] cfg_data   = 16'h0000;
  logic        dma_stall  = 1'b0;
  logic        stall_en   = 1'b0;
  logic        dma_active, batch_active, cfg_busy, word_valid;
  logic [15:0] word_data, frame_ptr;
  logic [15:0] exp_q[$];
  logic [15:0] ptr_exp    = 16'h0000;
  int          n_mismatch = 0;
  int          cmp_count  = 0;

  always #20 mclk = ~mclk;
  // Random stalls make the device wait on acknowledges with words still buffered.
  always @(posedge mclk) dma_stall <= stall_en && ($urandom_range(0, 3) == 0);

  rxd_if rxd_if_i (.MCLK(mclk), .RST_N(rst_n));
  rxd_dev #(.RAM_AW(10), .DESC_AW(3)) rxd_dev_i (.BUS(rxd_if_i), .RX_SOF(rx_sof), .RX_DA_PASS(rx_da_pass),
    .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_LAST(rx_last), .RX_GOOD(rx_good), .RX_STAT(rx_stat),
    .PIO_COMMIT(pio_commit), .PIO_SKIP(pio_skip), .DMA_ACTIVE(dma_active), .BATCH_ACTIVE(batch_active));
  rxd_host rxd_host_i (.BUS(rxd_if_i), .DRV_EN(drv_en), .CFG_WR(cfg_wr), .CFG_ADDR(cfg_addr), .CFG_DATA(cfg_data),
    .DMA_STALL(dma_stall), .CFG_BUSY(cfg_busy), .WORD_VALID(word_valid), .WORD_DATA(word_data),
    .FRAME_PTR(frame_ptr));
  rxd_props rxd_props_i (.MCLK(mclk), .RST_N(rst_n), .reg_rd(rxd_if_i.reg_rd), .reg_wr(rxd_if_i.reg_wr),
    .reg_addr(rxd_if_i.reg_addr), .reg_wdata(rxd_if_i.reg_wdata), .reg_rdata(rxd_if_i.reg_rdata),
    .dma_req(rxd_if_i.dma_req), .dma_ack_n(rxd_if_i.dma_ack_n), .dma_data(rxd_if_i.dma_data),
    .irq(rxd_if_i.irq));

  task automatic give_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  // Each word the host controller hands up must be the oldest one still noted.
  always @(posedge mclk) begin
    if (word_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("FAIL dma word expected none seen %h", word_data);
      end else begin
        cmp_val("dma word", exp_q.pop_front(), word_data);
      end
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // Bounded wait for the driver loop to idle with every noted word delivered.
  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    // A raised interrupt means the driver loop is about to run, so the host is not idle yet.
    while ((cfg_busy !== 1'b0 || rxd_if_i.irq !== 1'b0 || exp_q.size() != 0) && k < lim) begin
      @(posedge mclk);
      k++;
    end
    if (k >= lim) begin
      n_mismatch++;
      $display("FAIL idle wait expected done seen timeout");
      give_verdict();
    end
  endtask : wait_idle

  task automatic cfg_write(input logic [15:0] addr, input logic [15:0] data);
    wait_idle(20000);
    cfg_wr   <= 1'b1;
    cfg_addr <= addr;
    cfg_data <= data;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    // Let an edge pass so that a following write does not raise the strobe in the same step.
    @(posedge mclk);
  endtask : cfg_write

  // Send one frame; when it should reach the host, note status, byte length and data in order.
  task automatic send_frame(input int n, input logic pass, input logic good, input logic dma, input int gap);
    logic [15:0] st;
    logic [15:0] w;
    st = 16'($urandom);
    rx_sof     <= 1'b1;
    rx_da_pass <= pass;
    @(posedge mclk);
    rx_sof <= 1'b0;
    if (dma) begin
      exp_q.push_back(st);
      exp_q.push_back(16'(2 * n));
      ptr_exp = 16'((32'(ptr_exp) + 32'((2 * n + 7) / 4 * 4)) % 32'(RING_SMALL));
    end
    for (int i = 0; i < n; i++) begin
      w = 16'($urandom);
      rx_valid <= 1'b1;
      rx_data  <= w;
      rx_last  <= (i == n - 1);
      rx_good  <= good;
      rx_stat  <= st;
      if (dma) exp_q.push_back(w);
      @(posedge mclk);
    end
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    tick(gap);
  endtask : send_frame

  initial begin
    void'($urandom(84169));
    tick(5);
    rst_n  <= 1'b1;
    drv_en <= 1'b1;
    @(posedge mclk);
    // Memory mode: a good frame stays on chip, then programmed access retires it.
    cfg_write(OFS_RECEIVE_CONTROL, 16'h0100);
    cfg_write(OFS_BUFFER_CONFIG_REGISTER, 16'h0080);
    send_frame(4, 1'b1, 1'b1, 1'b0, 50);
    cmp_val("dma active", 1'b0, dma_active);
    pio_skip <= 1'b1;
    @(posedge mclk);
    pio_skip <= 1'b0;
    $display("test memory mode done");
    // Exclusive DMA with stalls, back-to-back frames, a filtered frame and a bad frame.
    cfg_write(OFS_RECEIVE_CONFIG_REGISTER, 16'h0200);
    stall_en <= 1'b1;
    for (int f = 0; f < 6; f++) send_frame($urandom_range(1, 12), f != 2, f != 3, f != 2 && f != 3, $urandom_range(2, 30));
    wait_idle(20000);
    stall_en <= 1'b0;
    cmp_val("frame pointer", ptr_exp, frame_ptr);
    $display("test exclusive dma done");
    // Auto-switch: a large frame fits, a committed frame blocks the switch until it is skipped.
    cfg_write(OFS_RECEIVE_CONFIG_REGISTER, 16'h0400);
    tick(20);
    cmp_val("dma active", 1'b0, dma_active);
    send_frame(300, 1'b1, 1'b1, 1'b0, 5);
    cmp_val("dma active", 1'b0, dma_active);
    pio_commit <= 1'b1;
    send_frame(4, 1'b1, 1'b1, 1'b1, 100);
    cmp_val("words held", 16'h0006, 16'(exp_q.size()));
    pio_skip   <= 1'b1;
    pio_commit <= 1'b0;
    @(posedge mclk);
    pio_skip <= 1'b0;
    tick(2);
    cmp_val("dma active", 1'b1, dma_active);
    wait_idle(20000);
    tick(20);
    cmp_val("dma active", 1'b0, dma_active);
    cmp_val("frame pointer", ptr_exp, frame_ptr);
    $display("test auto switch done");
    // Batching: spaced good frames open a cycle, a long silence closes it.
    cfg_write(OFS_RECEIVE_CONFIG_REGISTER, 16'h0380);
    for (int f = 0; f < 3; f++) send_frame(4, 1'b1, 1'b1, 1'b1, 300);
    cmp_val("batch active", 1'b1, batch_active);
    tick(1100);
    cmp_val("batch active", 1'b0, batch_active);
    wait_idle(20000);
    cmp_val("frame pointer", ptr_exp, frame_ptr);
    $display("test batch done");
    give_verdict();
  end
endmodule : test_rx_dma_mode_control
